// ==== msmrc_pkg.sv ====
// Shared constants and types for the serial memory read control block
package msmrc_pkg;
    localparam logic [7:0]  CFG_RESET     = 8'h40;
    localparam logic [7:0]  CFG_WMASK     = 8'hc2;
    localparam int          CFG_QUAD_BIT  = 1;
    localparam logic [16:0] ADDR_TOP      = 17'h1ffff;
    localparam logic [4:0]  OPC_BITS      = 5'h08;
    localparam logic [4:0]  ADDR_BITS     = 5'h18;
    localparam logic [4:0]  MODE_BITS     = 5'h08;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [7:0]  OP_CFG_WRITE  = 8'h87;
    localparam logic [7:0]  OP_STORE      = 8'h8c;
    localparam logic [7:0]  OP_RECALL     = 8'h8d;
    localparam logic [7:0]  OP_AS_ON      = 8'h8e;
    localparam logic [7:0]  OP_AS_OFF     = 8'h8f;

    typedef enum logic [1:0] {
        MSMRC_P1, MSMRC_P2, MSMRC_P4
    } msmrc_proto_t;
    typedef enum logic [2:0] {
        PH_IDLE, PH_OPC, PH_ADDR, PH_WAIT, PH_DATA, PH_CFG, PH_STAT, PH_SKIP
    } msmrc_phase_t;
    typedef enum logic [1:0] {
        RK_PLAIN, RK_FAST, RK_DOR
    } msmrc_kind_t;
    typedef enum logic [3:0] {
        PC_NONE, PC_LOCK, PC_UNLOCK, PC_TO1, PC_TO2, PC_TO4,
        PC_STORE, PC_RECALL, PC_AS_ON, PC_AS_OFF
    } msmrc_cmd_t;
endpackage

// ==== msmrc_buf_if.sv ====
// Handshake bundle between the control core and its read-data buffer
`timescale 1ns/1ps
`default_nettype none
interface msmrc_buf_if;
    logic       push_valid;
    logic       push_ready;
    logic [7:0] push_data;
    logic       pop_valid;
    logic       pop_ready;
    logic [7:0] pop_data;
    logic [1:0] level;
    logic       flush;
    modport buf_side (input push_valid, push_data, pop_ready, flush,
                      output push_ready, pop_valid, pop_data, level);
    modport user_side (output push_valid, push_data, pop_ready, flush,
                       input push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// ==== msmrc_buf.sv ====
// Two-entry read-data buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module msmrc_buf
    import msmrc_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Buffer ports
    msmrc_buf_if.buf_side     bif
);
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic [1:0]      cnt;
        logic            rd;
        logic            wr;
    } msmrc_buf_state_t;

    msmrc_buf_state_t s;
    msmrc_buf_state_t next_s;
    logic             push;
    logic             pop;

    assign bif.push_ready = (s.cnt != 2'h2);
    assign bif.pop_valid  = (s.cnt != 2'h0);
    assign bif.pop_data   = s.mem[s.rd];
    assign bif.level      = s.cnt;
    assign push = bif.push_valid & bif.push_ready;
    assign pop  = bif.pop_valid & bif.pop_ready;

    always_comb begin
        next_s = s;
        if (bif.flush) begin
            next_s.cnt = 2'h0;
            next_s.rd  = 1'b0;
            next_s.wr  = 1'b0;
        end else begin
            if (push) begin
                next_s.mem[s.wr] = bif.push_data;
                next_s.wr        = ~s.wr;
            end
            if (pop) begin
                next_s.rd = ~s.rd;
            end
            next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ==== msmrc_core.sv ====
// Serial memory command front end: link decode, config, latch, reads
// Function
// R01: While busy, only the status read is accepted; flag reads zero idle.
// R02: State register values become nonvolatile only after a save.
// R03: Hardware save commits register values only if the array was written.
// R04: Config writes persist only after save; hardware save needs array write.
// R05: Config is eight bits, quad bit 1 resets 0, bit 6 resets 1.
// R06: With quad set, guard pin becomes line 2 and guard reads active.
// R07: Host sets quad bit before any four-lane command.
// R08: Host writes 0x42 to set quad bit, 0x40 to clear it.
// R09: Write-lock clears the unlock latch at chip select rise.
// R10: Write-unlock sets the latch; latch is zero after power-up.
// R11: With latch clear, writes and save commands are ignored.
// R12: Latch clears after register write, save, restore, autosave commands.
// R13: Two-lane mode command moves all phases onto lines 0 and 1.
// R14: Four-lane mode command uses lines 0-3 and leaves quad bit alone.
// R15: One-lane mode command returns to single line, quad bit unchanged.
// R16: Host issues no reads while a save or restore is busy.
// R17: Read takes three address bytes forming a 17-bit address.
// R18: Data leaves on falling edges MSB first; address wraps at top.
// R19: Chip select rise ends a read at any point.
// R20: Plain read in two or four lanes has one dummy cycle.
// R21: Two-lane data puts D7 on line 1; four-lane puts D7 on line 3.
// R22: Host sets quad bit before plain read in four-lane mode.
// R23: Prefetch read takes a mode byte before data and wraps.
// R24: Dual-output read takes command on one line, data on two.
// R25: Latch is status bit 1 and gates write and save commands.
// R26: Data lines stay high impedance unless read data is driven.
`timescale 1ns/1ps
`default_nettype none
module msmrc_core
    import msmrc_pkg::*;
#(
    parameter logic [7:0] OP_STATUS_READ = 8'h05,
    parameter logic [7:0] OP_UNLOCK      = 8'h06,
    parameter logic [7:0] OP_LOCK        = 8'h04,
    parameter logic [7:0] OP_READ        = 8'h03,
    parameter logic [7:0] OP_FAST_READ   = 8'h0b,
    parameter logic [7:0] OP_DUAL_OUT    = 8'h3b,
    parameter logic [7:0] OP_TWO_LANE    = 8'h37,
    parameter logic [7:0] OP_FOUR_LANE   = 8'h38,
    parameter logic [7:0] OP_ONE_LANE    = 8'hff
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Serial link pins
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe_n,
    input  wire logic        hw_save_busy_pin_n,
    // Memory read port
    output logic             mem_req_valid,
    input  wire logic        mem_req_ready,
    output logic      [16:0] mem_req_addr,
    input  wire logic        mem_rsp_valid,
    output logic             mem_rsp_ready,
    input  wire logic [7:0]  mem_rsp_data,
    // System side
    input  wire logic        op_busy,
    input  wire logic        hw_save_req,
    input  wire logic        array_written,
    output logic             store_req,
    output logic             recall_req,
    output logic             autosave_enabled,
    output logic             quad_enable,
    output logic             write_guard_active,
    output logic      [7:0]  state_register,
    output logic      [7:0]  interface_config,
    output logic      [7:0]  interface_config_saved
);
    typedef struct packed {
        logic [2:0]      sck_q;
        logic [1:0]      cs_q;
        logic            cs_d;
        logic [1:0][3:0] io_q;
        logic [1:0]      hsb_q;
        logic            busy;
        msmrc_phase_t    phase;
        msmrc_proto_t    proto;
        msmrc_kind_t     kind;
        msmrc_cmd_t      pend;
        logic [23:0]     sr;
        logic [4:0]      cnt;
        logic [4:0]      wait_bits;
        logic [16:0]     fetch_addr;
        logic            fetch_busy;
        logic [7:0]      osr;
        logic [3:0]      ocnt;
        logic [3:0]      io_out;
        logic [3:0]      io_oe_n;
        logic            unlock;
        logic            cfg_done;
        logic [7:0]      cfg;
        logic [7:0]      cfg_nv;
        logic            dirty;
        logic            autosave;
        logic            store_p;
        logic            recall_p;
    } msmrc_core_t;

    msmrc_core_t s;
    msmrc_core_t next_s;
    msmrc_buf_if bif ();

    logic        rise;
    logic        fall;
    logic        cs_hi;
    logic        cs_rise;
    logic        reading;
    logic        opc_done;
    logic [2:0]  in_l;
    logic [2:0]  out_l;
    logic [3:0]  in_bits;
    logic [23:0] sr_in;
    logic [4:0]  cnt_in;
    logic [7:0]  b;
    logic [7:0]  status;

    msmrc_buf u_buf (
        .clk     (clk),
        .reset_n (reset_n),
        .bif     (bif)
    );

    function automatic logic [2:0] lanes(input msmrc_proto_t p);
        unique case (p)
            MSMRC_P1: lanes = 3'h1;
            MSMRC_P2: lanes = 3'h2;
            MSMRC_P4: lanes = 3'h4;
        endcase
    endfunction

    assign rise    = s.sck_q[1] & ~s.sck_q[2];
    assign fall    = ~s.sck_q[1] & s.sck_q[2];
    assign cs_hi   = s.cs_q[1];
    assign cs_rise = cs_hi & ~s.cs_d;
    assign reading = (s.phase == PH_WAIT) | (s.phase == PH_DATA);
    assign in_l    = lanes(s.proto);
    assign out_l   = (s.kind == RK_DOR && s.phase == PH_DATA) ? 3'h2 : in_l;
    assign cnt_in  = s.cnt + {2'h0, in_l};
    assign status  = {6'h00, s.unlock, s.busy}; // R25 R01
    assign opc_done = !cs_hi && rise && s.phase == PH_OPC
                      && cnt_in == OPC_BITS;

    // Input lanes: SI alone, lines 1:0, or lines 3:0
    always_comb begin
        unique case (in_l)
            3'h2:    in_bits = {2'h0, s.io_q[1][1:0]}; // R13
            3'h4:    in_bits = s.io_q[1]; // R14
            default: in_bits = {3'h0, s.io_q[1][0]};
        endcase
        unique case (in_l)
            3'h2:    sr_in = {s.sr[21:0], in_bits[1:0]};
            3'h4:    sr_in = {s.sr[19:0], in_bits};
            default: sr_in = {s.sr[22:0], in_bits[0]};
        endcase
    end

    // Memory fetch and buffer hookup
    assign mem_req_valid  = reading & ~s.fetch_busy & (bif.level != 2'h2);
    assign mem_req_addr   = s.fetch_addr;
    assign bif.push_valid = mem_rsp_valid & reading;
    assign bif.push_data  = mem_rsp_data;
    assign mem_rsp_ready  = reading ? bif.push_ready : 1'b1;
    assign bif.flush      = cs_hi; // R19
    assign bif.pop_ready  = fall & !cs_hi & (s.phase == PH_DATA)
                            & (s.ocnt == BYTE_BITS);

    always_comb begin
        next_s = s;
        b = s.osr;
        next_s.sck_q = {s.sck_q[1:0], sck};
        next_s.cs_q  = {s.cs_q[0], cs_n};
        next_s.cs_d  = s.cs_q[1];
        next_s.io_q  = {s.io_q[0], io_in};
        next_s.hsb_q = {s.hsb_q[0], hw_save_busy_pin_n};
        next_s.busy  = op_busy | ~s.hsb_q[1];
        next_s.store_p  = 1'b0;
        next_s.recall_p = 1'b0;
        if (mem_req_valid && mem_req_ready) begin
            next_s.fetch_addr = s.fetch_addr + 17'h00001; // R18
            next_s.fetch_busy = 1'b1;
        end
        if (mem_rsp_valid && mem_rsp_ready) begin
            next_s.fetch_busy = 1'b0;
        end
        if (cs_hi) begin
            next_s.phase   = PH_IDLE; // R19
            next_s.io_oe_n = 4'hf; // R26
            next_s.cnt     = 5'h00;
            if (cs_rise) begin
                next_s.pend     = PC_NONE;
                next_s.cfg_done = 1'b0;
                unique case (s.pend)
                    PC_LOCK:   next_s.unlock = 1'b0; // R09
                    PC_UNLOCK: next_s.unlock = 1'b1; // R10
                    PC_TO1:    next_s.proto = MSMRC_P1; // R15
                    PC_TO2:    next_s.proto = MSMRC_P2; // R13
                    PC_TO4:    next_s.proto = MSMRC_P4; // R14
                    PC_STORE: begin
                        next_s.store_p = 1'b1;
                        next_s.cfg_nv  = s.cfg; // R02 R04
                        next_s.dirty   = 1'b0;
                        next_s.unlock  = 1'b0; // R12
                    end
                    PC_RECALL: begin
                        next_s.recall_p = 1'b1;
                        next_s.cfg      = s.cfg_nv;
                        next_s.unlock   = 1'b0; // R12
                    end
                    PC_AS_ON: begin
                        next_s.autosave = 1'b1;
                        next_s.unlock   = 1'b0; // R12
                    end
                    PC_AS_OFF: begin
                        next_s.autosave = 1'b0;
                        next_s.unlock   = 1'b0; // R12
                    end
                    default: begin
                    end
                endcase
                if (s.cfg_done) begin
                    next_s.unlock = 1'b0; // R12
                end
            end
        end else begin
            if (s.phase == PH_IDLE) begin
                next_s.phase = PH_OPC;
                next_s.pend  = PC_NONE;
                next_s.kind  = RK_PLAIN;
            end
            if (rise) begin
                next_s.sr  = sr_in;
                next_s.cnt = cnt_in;
                unique case (s.phase)
                    PH_OPC: begin
                        if (cnt_in == OPC_BITS) begin
                            next_s.cnt   = 5'h00;
                            next_s.phase = PH_SKIP;
                            if (sr_in[7:0] == OP_STATUS_READ) begin
                                next_s.phase = PH_STAT;
                                next_s.ocnt  = BYTE_BITS;
                            end else if (s.busy) begin
                                next_s.phase = PH_SKIP; // R01
                            end else if (sr_in[7:0] == OP_READ) begin
                                next_s.phase = PH_ADDR;
                            end else if (sr_in[7:0] == OP_FAST_READ) begin
                                next_s.phase = PH_ADDR;
                                next_s.kind  = RK_FAST; // R23
                            end else if (sr_in[7:0] == OP_DUAL_OUT
                                         && s.proto == MSMRC_P1) begin
                                next_s.phase = PH_ADDR;
                                next_s.kind  = RK_DOR; // R24
                            end else if (sr_in[7:0] == OP_UNLOCK) begin
                                next_s.pend = PC_UNLOCK; // R10
                            end else if (sr_in[7:0] == OP_LOCK) begin
                                next_s.pend = PC_LOCK; // R09
                            end else if (sr_in[7:0] == OP_ONE_LANE) begin
                                next_s.pend = PC_TO1;
                            end else if (sr_in[7:0] == OP_TWO_LANE) begin
                                next_s.pend = PC_TO2;
                            end else if (sr_in[7:0] == OP_FOUR_LANE) begin
                                next_s.pend = PC_TO4;
                            end else if (!s.unlock) begin
                                next_s.phase = PH_SKIP; // R11
                            end else if (sr_in[7:0] == OP_CFG_WRITE) begin
                                next_s.phase = PH_CFG; // R25
                            end else if (sr_in[7:0] == OP_STORE) begin
                                next_s.pend = PC_STORE;
                            end else if (sr_in[7:0] == OP_RECALL) begin
                                next_s.pend = PC_RECALL;
                            end else if (sr_in[7:0] == OP_AS_ON) begin
                                next_s.pend = PC_AS_ON;
                            end else if (sr_in[7:0] == OP_AS_OFF) begin
                                next_s.pend = PC_AS_OFF;
                            end
                        end
                    end
                    PH_ADDR: begin
                        if (cnt_in == ADDR_BITS) begin
                            next_s.fetch_addr = sr_in[16:0]; // R17
                            next_s.cnt        = 5'h00;
                            next_s.ocnt       = BYTE_BITS;
                            if (s.kind == RK_PLAIN
                                && s.proto == MSMRC_P1) begin
                                next_s.phase = PH_DATA;
                            end else begin
                                next_s.phase     = PH_WAIT;
                                next_s.wait_bits = (s.kind == RK_PLAIN)
                                    ? {2'h0, in_l} : MODE_BITS; // R20 R23
                            end
                        end
                    end
                    PH_WAIT: begin
                        if (cnt_in == s.wait_bits) begin
                            next_s.phase = PH_DATA;
                        end
                    end
                    PH_CFG: begin
                        if (cnt_in == OPC_BITS) begin
                            next_s.cfg = (sr_in[7:0] & CFG_WMASK)
                                       | (s.cfg & ~CFG_WMASK); // R05
                            next_s.cfg_done = 1'b1;
                            next_s.phase    = PH_SKIP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (fall && (s.phase == PH_DATA || s.phase == PH_STAT)) begin
                if (s.ocnt == BYTE_BITS) begin
                    if (s.phase == PH_STAT) begin
                        b = status;
                    end else begin
                        b = bif.pop_valid ? bif.pop_data : 8'h00;
                    end
                    next_s.ocnt = {1'b0, out_l};
                end else begin
                    next_s.ocnt = s.ocnt + {1'b0, out_l};
                end
                unique case (out_l)
                    3'h2: begin
                        next_s.io_out  = {2'h0, b[7:6]}; // R21 R24
                        next_s.io_oe_n = 4'hc;
                        next_s.osr     = {b[5:0], 2'h0};
                    end
                    3'h4: begin
                        next_s.io_out  = b[7:4]; // R21
                        next_s.io_oe_n = 4'h0;
                        next_s.osr     = {b[3:0], 4'h0};
                    end
                    default: begin
                        next_s.io_out  = {2'h0, b[7], 1'b0}; // R18
                        next_s.io_oe_n = 4'hd;
                        next_s.osr     = {b[6:0], 1'b0};
                    end
                endcase
            end
        end
        if (hw_save_req && s.dirty) begin
            next_s.cfg_nv = s.cfg; // R03 R04
            next_s.dirty  = 1'b0;
        end
        if (array_written) begin
            next_s.dirty = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s         <= '0;
            s.cs_q    <= 2'h3;
            s.cs_d    <= 1'b1;
            s.hsb_q   <= 2'h3;
            s.io_oe_n <= 4'hf;
            s.cfg     <= CFG_RESET; // R05
            s.cfg_nv  <= CFG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign io_out                 = s.io_out;
    assign io_oe_n                = s.io_oe_n;
    assign store_req              = s.store_p;
    assign recall_req             = s.recall_p;
    assign autosave_enabled       = s.autosave;
    assign quad_enable            = s.cfg[CFG_QUAD_BIT];
    assign write_guard_active     = quad_enable | ~s.io_q[1][2]; // R06
    assign state_register         = status;
    assign interface_config       = s.cfg;
    assign interface_config_saved = s.cfg_nv;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_cs_rise;
        s.cs_q[1] && !s.cs_d;
    endsequence
    sequence s_cs_idle;
        s.cs_q[1] [*2];
    endsequence

    a_busy_ignore: assert property (opc_done && s.busy // R01
        && sr_in[7:0] != OP_STATUS_READ |=> s.phase == PH_SKIP)
        else $error("busy command not ignored");
    a_lock_clears: assert property (s_cs_rise ##0 s.pend == PC_LOCK // R09
        |=> !s.unlock ##1 !s.unlock)
        else $error("lock did not clear latch");
    a_unlock_sets: assert property (s_cs_rise ##0 s.pend == PC_UNLOCK // R10
        |=> s.unlock)
        else $error("unlock did not set latch");
    a_locked_cfg: assert property (opc_done && !s.unlock // R11
        |=> s.phase != PH_CFG)
        else $error("config write taken while locked");
    a_cfg_latch: assert property (s_cs_rise ##0 s.cfg_done // R12
        |=> !s.unlock)
        else $error("latch kept after config write");
    a_addr_wrap: assert property (mem_req_valid && mem_req_ready // R18
        && mem_req_addr == ADDR_TOP |=> mem_req_addr == 17'h00000)
        else $error("address did not wrap");
    a_lines_idle: assert property (s_cs_idle |-> io_oe_n == 4'hf) // R26
        else $error("line driven while deselected");
    a_quad_guard: assert property (quad_enable |-> write_guard_active) // R06
        else $error("guard not active in quad");
    a_cfg_fixed: assert property (interface_config[5:2] == 4'h0 // R05
        && !interface_config[0])
        else $error("fixed config bits changed");
    a_hw_save_clean: assert property (hw_save_req && !s.dirty // R03
        && !(cs_rise && s.pend == PC_STORE)
        |=> $stable(interface_config_saved))
        else $error("clean hardware save committed");
    a_mode_quad: assert property (s_cs_rise ##0 (s.pend == PC_TO1 // R15
        || s.pend == PC_TO4) |=> $stable(quad_enable))
        else $error("mode change altered quad bit");
endmodule
`default_nettype wire

// ==== msmrc_top_note_unused.sv ====
// Reserved empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== msmrc_mem.sv ====
// Array model answering the core's byte fetches
`timescale 1ns/1ps
`default_nettype none
module msmrc_mem (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Fetch handshake
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [16:0] req_addr,
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic      [7:0]  rsp_data
);
    assign req_ready = !rsp_valid;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else if (rsp_valid && rsp_ready) begin
            rsp_valid <= 1'b0;
            rsp_data  <= ~rsp_data;
        end else if (req_valid && !rsp_valid) begin
            rsp_valid <= 1'b1;
            rsp_data  <= req_addr[7:0] ^ {req_addr[16], 7'h55};
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Host-side bench for the serial memory read control core
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0, reset_n = 1'b0, sck = 1'b0, cs_n = 1'b1;
    logic        op_busy = 1'b0, qv, qr, rv, rr, write_guard_active;
    logic        hsb_n = 1'b1, hsr = 1'b0, aw = 1'b0, stq, rcq, asv, qe;
    logic [7:0]  pulses = 8'h00;
    logic [3:0]  io_in = 4'h0, io_out, io_oe_n;
    logic [16:0] qa;
    logic [7:0]  rd_d, q, state_register, interface_config;
    logic [7:0]  interface_config_saved;
    int          ln = 1, n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #10 clk = ~clk;
    msmrc_core i_dut (.clk, .reset_n, .sck, .cs_n, .io_in, .io_out,
        .io_oe_n, .hw_save_busy_pin_n(hsb_n), .mem_req_valid(qv),
        .mem_req_ready(qr), .mem_req_addr(qa), .mem_rsp_valid(rv),
        .mem_rsp_ready(rr), .mem_rsp_data(rd_d), .op_busy,
        .hw_save_req(hsr), .array_written(aw), .store_req(stq),
        .recall_req(rcq), .autosave_enabled(asv), .quad_enable(qe),
        .write_guard_active, .state_register, .interface_config,
        .interface_config_saved);
    msmrc_mem i_mem (.clk, .reset_n, .req_valid(qv), .req_ready(qr),
        .req_addr(qa), .rsp_valid(rv), .rsp_ready(rr), .rsp_data(rd_d));
    always @(negedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    // Counts store pulses in the low nibble, restore pulses in the high
    always @(posedge clk)
        pulses <= pulses + {3'h0, rcq, 3'h0, stq};
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(int n);
        repeat (n) @(negedge clk);
    endtask
    // Shifts nb bits over w lanes, collecting what the core drives
    task automatic sh(int w, int nb, logic [7:0] d);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        for (int i = nb - w; i >= 0; i -= w) begin
            io_in = 4'(d >> i) & m;
            sck = 1'b1;
            tk(2);
            q = (q << w) | 8'(w == 1 ? {3'h0, io_out[1]} : io_out & m);
            tk(2);
            sck = 1'b0;
            tk(4);
        end
    endtask
    task automatic go(logic [7:0] op);
        cs_n = 1'b0;
        tk(4);
        sh(ln, 8, op);
    endtask
    task automatic stop;
        cs_n = 1'b1;
        tk(8);
    endtask
    task automatic cmd(logic [7:0] op, int n = 1);
        go(op);
        stop();
        ln = n;
    endtask
    task automatic wcfg(logic [7:0] d);
        cmd(8'h06);
        go(8'h87);
        sh(1, 8, d);
        stop();
    endtask
    // Optional array write pulse, then a hardware save pulse
    task automatic hs(logic w);
        aw = w;
        tk(1);
        aw = 1'b0;
        hsr = 1'b1;
        tk(1);
        hsr = 1'b0;
        tk(1);
    endtask
    // Read two bytes; dn filler bits after the address, dl data lanes
    task automatic rd(logic [7:0] op, logic [16:0] a, int dn, int dl);
        logic [16:0] b;
        go(op);
        for (int j = 16; j >= 0; j -= 8)
            sh(ln, 8, 8'(a >> j));
        if (dn > 0)
            sh(ln, dn, 8'h00);
        for (int k = 0; k < 2; k++) begin
            sh(dl, 8, 8'h00);
            b = 17'(a + k);
            chk("data", b[7:0] ^ {b[16], 7'h55}, q);
        end
        chk("oe", {4'h0, ~(dl == 1 ? 4'h2 : 4'((1 << dl) - 1))},
            {4'h0, io_oe_n});
        stop();
        chk("idle oe", 8'h0f, {4'h0, io_oe_n});
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        tk(6);
        reset_n = 1'b1;
        tk(4);
        chk("cfg", 8'h40, interface_config);
        chk("sr", 8'h00, state_register);
        go(8'h87);
        sh(1, 8, 8'h42);
        stop();
        chk("cfg", 8'h40, interface_config);
        io_in = 4'h4;
        tk(2);
        chk("guard", 8'h00, {7'h0, write_guard_active});
        cmd(8'h06);
        chk("sr", 8'h02, state_register);
        cmd(8'h04);
        chk("sr", 8'h00, state_register);
        op_busy = 1'b1;
        cmd(8'h06);
        op_busy = 1'b0;
        hsb_n = 1'b0;
        go(8'h05);
        sh(1, 8, 8'h00);
        chk("status", 8'h01, q);
        stop();
        hsb_n = 1'b1;
        wcfg(8'h42);
        chk("sr", 8'h00, state_register);
        io_in = 4'h4;
        tk(2);
        chk("guard", 8'h01, {7'h0, write_guard_active});
        chk("nv", 8'h40, interface_config_saved);
        cmd(8'h06);
        cmd(8'h8c);
        chk("nv", 8'h42, interface_config_saved);
        wcfg(8'h40);
        hs(1'b0);
        chk("nv", 8'h42, interface_config_saved);
        cmd(8'h06);
        cmd(8'h8d);
        chk("cfg", 8'h42, interface_config);
        chk("sr", 8'h00, state_register);
        wcfg(8'h40);
        hs(1'b1);
        chk("nv", 8'h40, interface_config_saved);
        cmd(8'h06);
        cmd(8'h8e);
        chk("autosave", 8'h01, {7'h0, asv});
        chk("sr", 8'h00, state_register);
        chk("pulses", 8'h11, pulses);
        wcfg(8'h42);
        $display("test registers done");
        rd(8'h03, 17'h1ffff, 0, 1);
        rd(8'h0b, 17'h00100, 8, 1);
        rd(8'h3b, 17'h0abcd, 8, 2);
        cmd(8'h37, 2);
        rd(8'h03, 17'h10000, 2, 2);
        cmd(8'hff);
        cmd(8'h38, 4);
        rd(8'h03, 17'h00012, 4, 4);
        cmd(8'hff);
        chk("cfg", 8'h42, interface_config);
        chk("quad", 8'h01, {7'h0, qe});
        $display("test reads done");
        conclude();
    end
endmodule
`default_nettype wire
